// file: design/drive_io_threshold_logic.v
// Purpose: Programmable terminal logic: output type, characteristic frequency and
//          current comparators, frequency arrival and digital input decoding.
// Assumes: Quantities from the control core arrive on the system clock; terminal
//          inputs are asynchronous pins.
// Notes:   Frequencies in 0.01 Hz units, current in whole units.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "drive_io_defines.vh"

module drive_io_threshold_logic #(
   parameter W           = 16,
   parameter RATED_CURRENT = 16'h0064
) (
   input  wire         i_clk_sys,
   input  wire         i_reset_n,
   input  wire [3:0]   i_addr,
   input  wire [15:0]  i_wdata,
   input  wire         i_wr,
   input  wire         i_rd,
   output reg  [15:0]  o_rdata,
   input  wire [W-1:0] i_run_freq,
   input  wire [W-1:0] i_target_freq,
   input  wire [W-1:0] i_out_current,
   input  wire         i_digital_input_one,
   input  wire         i_digital_input_two,
   input  wire         i_digital_input_three,
   output reg          o_first_digital_output,
   output reg          o_second_digital_output,
   output reg          o_relay_output,
   output reg          o_run_cmd,
   output reg          o_stop_cmd
);

   // =====================================================================
   // Configuration registers and internal state
   reg         output_type_q;
   reg  [15:0] relay_fn_q;
   reg  [15:0] out1_fn_q;
   reg  [15:0] out2_fn_q;
   reg  [15:0] char_freq_one_q;
   reg  [15:0] char_freq_two_q;
   reg  [6:0]  char_freq_width_q;
   reg  [15:0] char_current_level_q;
   reg  [6:0]  char_current_width_q;
   reg  [15:0] arrival_thr_q;
   reg  [15:0] in_fn_q [0:2];
   reg  [15:0] pulse_period_q;
   reg  [15:0] pulse_cnt_q;
   reg         pulse_q;
   reg         arrival_q;
   reg  [2:0]  sync1_q;
   reg  [2:0]  sync2_q;
   reg  [2:0]  sync3_q;
   reg  [2:0]  din_q;
   wire        freq_one_on;
   wire        freq_two_on;
   wire        current_on;
   wire [W-1:0] arrival_low;
   wire [2:0]  din_raw;
   reg         run_d;
   reg         stop_d;
   integer     k;
   integer     j;

   // Clamp a percentage setting to its legal range.
   function [6:0] clamp_pct;
      input [15:0] v;
      begin
         clamp_pct = (v > `MAX_WIDTH_PCT) ? 7'h64 : v[6:0];
      end
   endfunction

   // Map an output function code onto the terminal level.
   function fn_level;
      input [15:0] fn;
      input        f1;
      input        f2;
      input        cur;
      input        arr;
      begin
         case (fn)
            `FN_CHAR_FREQ_ONE: fn_level = f1;
            `FN_CHAR_FREQ_TWO: fn_level = f2;
            `FN_CHAR_CURRENT:  fn_level = cur;
            `FN_FREQ_ARRIVAL:  fn_level = arr;
            default:           fn_level = 1'b0;
         endcase
      end
   endfunction

   // =====================================================================
   // Register writes. Out-of-range values are clamped rather than refused.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         output_type_q        <= `OUT_TYPE_LEVEL;
         relay_fn_q           <= `RST_OUTPUT_FUNCTION;
         out1_fn_q            <= `RST_OUTPUT_FUNCTION;
         out2_fn_q            <= `RST_OUTPUT_FUNCTION;
         char_freq_one_q      <= `RST_CHAR_FREQ_ONE;
         char_freq_two_q      <= `RST_CHAR_FREQ_TWO;
         char_freq_width_q    <= 7'h32;
         char_current_level_q <= RATED_CURRENT;
         char_current_width_q <= 7'h0a;
         arrival_thr_q        <= `RST_FREQ_ARRIVAL_THRESHOLD;
         in_fn_q[0]           <= `RST_INPUT_ONE_FUNCTION;
         in_fn_q[1]           <= `RST_INPUT_TWO_FUNCTION;
         in_fn_q[2]           <= `RST_INPUT_THREE_FUNCTION;
         pulse_period_q       <= `RST_PULSE_PERIOD;
      end else if (i_wr) begin
         case (i_addr)
            `REG_OUTPUT_TYPE_SELECT:     output_type_q <= i_wdata[0];
            `REG_RELAY_FUNCTION_SELECT:  relay_fn_q <= i_wdata;
            `REG_FIRST_OUTPUT_FUNCTION:  out1_fn_q <= i_wdata;
            `REG_SECOND_OUTPUT_FUNCTION: out2_fn_q <= i_wdata;
            `REG_CHAR_FREQ_ONE:          char_freq_one_q <= i_wdata;
            `REG_CHAR_FREQ_TWO:          char_freq_two_q <= i_wdata;
            `REG_CHAR_FREQ_WIDTH:        char_freq_width_q <= clamp_pct(i_wdata);
            `REG_CHAR_CURRENT_LEVEL: begin
               char_current_level_q <= (i_wdata > `MAX_CURRENT_LEVEL) ?
                                       `MAX_CURRENT_LEVEL : i_wdata;
            end
            `REG_CHAR_CURRENT_WIDTH:     char_current_width_q <= clamp_pct(i_wdata);
            `REG_FREQ_ARRIVAL_THRESHOLD: begin
               arrival_thr_q <= (i_wdata > `MAX_ARRIVAL_THRESHOLD) ?
                                `MAX_ARRIVAL_THRESHOLD : i_wdata;
            end
            `REG_INPUT_ONE_FUNCTION:     in_fn_q[0] <= i_wdata;
            `REG_INPUT_TWO_FUNCTION:     in_fn_q[1] <= i_wdata;
            `REG_INPUT_THREE_FUNCTION:   in_fn_q[2] <= i_wdata;
            `REG_PULSE_PERIOD: begin
               // Periods shorter than the minimum would exceed the pulse ceiling.
               pulse_period_q <= (i_wdata < `PULSE_MIN_PERIOD) ?
                                 `PULSE_PERIOD_FLOOR : i_wdata;
            end
            default: ;
         endcase
      end
   end

   // =====================================================================
   // Register reads; unmapped addresses read as zero.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            `REG_OUTPUT_TYPE_SELECT:     o_rdata <= {15'h0000, output_type_q};
            `REG_RELAY_FUNCTION_SELECT:  o_rdata <= relay_fn_q;
            `REG_FIRST_OUTPUT_FUNCTION:  o_rdata <= out1_fn_q;
            `REG_SECOND_OUTPUT_FUNCTION: o_rdata <= out2_fn_q;
            `REG_CHAR_FREQ_ONE:          o_rdata <= char_freq_one_q;
            `REG_CHAR_FREQ_TWO:          o_rdata <= char_freq_two_q;
            `REG_CHAR_FREQ_WIDTH:        o_rdata <= {9'h000, char_freq_width_q};
            `REG_CHAR_CURRENT_LEVEL:     o_rdata <= char_current_level_q;
            `REG_CHAR_CURRENT_WIDTH:     o_rdata <= {9'h000, char_current_width_q};
            `REG_FREQ_ARRIVAL_THRESHOLD: o_rdata <= arrival_thr_q;
            `REG_INPUT_ONE_FUNCTION:     o_rdata <= in_fn_q[0];
            `REG_INPUT_TWO_FUNCTION:     o_rdata <= in_fn_q[1];
            `REG_INPUT_THREE_FUNCTION:   o_rdata <= in_fn_q[2];
            `REG_PULSE_PERIOD:           o_rdata <= pulse_period_q;
            `REG_TERMINAL_STATUS: begin
               o_rdata <= {7'h00, din_q, freq_one_on, freq_two_on, current_on,
                           arrival_q, o_relay_output, o_first_digital_output};
            end
            default:                     o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // =====================================================================
   // Comparators. Both frequency comparators share the one width setting.
   hyst_compare #(.W(W)) u_freq_one (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_enable    (1'b1),
      .i_value     (i_run_freq),
      .i_level     (char_freq_one_q[W-1:0]),
      .i_width_pct (char_freq_width_q),
      .o_on        (freq_one_on)
   );

   hyst_compare #(.W(W)) u_freq_two (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_enable    (1'b1),
      .i_value     (i_run_freq),
      .i_level     (char_freq_two_q[W-1:0]),
      .i_width_pct (char_freq_width_q),
      .o_on        (freq_two_on)
   );

   hyst_compare #(.W(W)) u_current (
      .i_clk_sys   (i_clk_sys),
      .i_reset_n   (i_reset_n),
      .i_enable    (1'b1),
      .i_value     (i_out_current),
      .i_level     (char_current_level_q[W-1:0]),
      .i_width_pct (char_current_width_q),
      .o_on        (current_on)
   );

   // Arrival band floors at zero so a threshold above target cannot wrap.
   assign arrival_low = (i_target_freq > arrival_thr_q[W-1:0]) ?
                        (i_target_freq - arrival_thr_q[W-1:0]) : {W{1'b0}};

   // On at target minus threshold; off once running frequency reaches target.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         arrival_q <= 1'b0;
      end else if (i_run_freq >= i_target_freq) begin
         arrival_q <= 1'b0;
      end else if (i_run_freq >= arrival_low) begin
         arrival_q <= 1'b1;
      end
   end

   // =====================================================================
   // Pulse generator, half a period high and half low.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pulse_cnt_q <= 16'h0000;
         pulse_q     <= 1'b0;
      end else if (output_type_q != `OUT_TYPE_PULSE) begin
         pulse_cnt_q <= 16'h0000;
         pulse_q     <= 1'b0;
      end else if (pulse_cnt_q >= {1'b0, pulse_period_q[15:1]} - 16'h0001) begin
         pulse_cnt_q <= 16'h0000;
         pulse_q     <= ~pulse_q;
      end else begin
         pulse_cnt_q <= pulse_cnt_q + 16'h0001;
      end
   end

   // Terminal outputs, registered from the function map; in pulse mode the first output takes the pulse generator instead.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_first_digital_output  <= 1'b0;
         o_second_digital_output <= 1'b0;
         o_relay_output          <= 1'b0;
      end else begin
         if (output_type_q == `OUT_TYPE_PULSE) begin
            o_first_digital_output <= pulse_q;
         end else begin
            o_first_digital_output <= fn_level(out1_fn_q, freq_one_on, freq_two_on,
                                               current_on, arrival_q);
         end
         o_second_digital_output <= fn_level(out2_fn_q, freq_one_on, freq_two_on,
                                             current_on, arrival_q);
         o_relay_output <= fn_level(relay_fn_q, freq_one_on, freq_two_on,
                                    current_on, arrival_q);
      end
   end

   // =====================================================================
   // Digital inputs: three flops, a change counts once stages two and three agree.
   assign din_raw = {i_digital_input_three, i_digital_input_two, i_digital_input_one};

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1_q <= 3'b000;
         sync2_q <= 3'b000;
         sync3_q <= 3'b000;
         din_q   <= 3'b000;
      end else begin
         sync1_q <= din_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (k = 0; k < 3; k = k + 1) begin
            if (sync2_q[k] == sync3_q[k]) begin
               din_q[k] <= sync3_q[k];
            end
         end
      end
   end

   // Decode the input functions; other codes are outside this block.
   always @* begin
      run_d  = 1'b0;
      stop_d = 1'b0;
      for (j = 0; j < 3; j = j + 1) begin
         if (din_q[j] && (in_fn_q[j] == `IN_FN_RUN)) begin
            run_d = 1'b1;
         end
         if (din_q[j] && (in_fn_q[j] == `IN_FN_STOP)) begin
            stop_d = 1'b1;
         end
      end
   end

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_run_cmd  <= 1'b0;
         o_stop_cmd <= 1'b0;
      end else begin
         o_run_cmd  <= run_d;
         o_stop_cmd <= stop_d;
      end
   end

endmodule // drive_io_threshold_logic

// file: design/drive_io_defines.vh
// Purpose: Offsets, reset values, codes, limits and timing counts of the terminal logic.
// Assumes: A 10 MHz system clock and a 16-bit register bus.
// Notes:   Frequencies are in units of 0.01 Hz.
`ifndef DRIVE_IO_DEFINES_VH
`define DRIVE_IO_DEFINES_VH

// =====================================================================
// Register offsets
`define REG_OUTPUT_TYPE_SELECT       4'h0
`define REG_RELAY_FUNCTION_SELECT    4'h1
`define REG_FIRST_OUTPUT_FUNCTION    4'h2
`define REG_SECOND_OUTPUT_FUNCTION   4'h3
`define REG_CHAR_FREQ_ONE            4'h4
`define REG_CHAR_FREQ_TWO            4'h5
`define REG_CHAR_FREQ_WIDTH          4'h6
`define REG_CHAR_CURRENT_LEVEL       4'h7
`define REG_CHAR_CURRENT_WIDTH       4'h8
`define REG_FREQ_ARRIVAL_THRESHOLD   4'h9
`define REG_INPUT_ONE_FUNCTION       4'ha
`define REG_INPUT_TWO_FUNCTION       4'hb
`define REG_INPUT_THREE_FUNCTION     4'hc
`define REG_PULSE_PERIOD             4'hd
`define REG_TERMINAL_STATUS          4'he

// =====================================================================
// Reset values
`define RST_OUTPUT_TYPE              16'h0000
`define RST_CHAR_FREQ_ONE            16'h03e8
`define RST_CHAR_FREQ_TWO            16'h1388
`define RST_CHAR_FREQ_WIDTH          16'h0032
`define RST_CHAR_CURRENT_WIDTH       16'h000a
`define RST_FREQ_ARRIVAL_THRESHOLD   16'h0000
`define RST_INPUT_ONE_FUNCTION       16'h000b
`define RST_INPUT_TWO_FUNCTION       16'h0009
`define RST_INPUT_THREE_FUNCTION     16'h000f
`define RST_OUTPUT_FUNCTION          16'h0000
`define RST_PULSE_PERIOD             16'h00c8

// =====================================================================
// Codes and limits
`define OUT_TYPE_LEVEL               1'b0
`define OUT_TYPE_PULSE               1'b1
`define FN_CHAR_FREQ_ONE             16'h0002
`define FN_CHAR_FREQ_TWO             16'h0003
`define FN_FREQ_ARRIVAL              16'h000f
`define FN_CHAR_CURRENT              16'h0011
`define IN_FN_NONE                   16'h0000
`define IN_FN_RUN                    16'h0001
`define IN_FN_STOP                   16'h0002
`define MAX_WIDTH_PCT                16'h0064
`define MAX_CURRENT_LEVEL            16'h1388
`define MAX_ARRIVAL_THRESHOLD        16'h01f4

// =====================================================================
// Timing
`define CLK_FREQ_HZ                  10000000
`define PULSE_MAX_HZ                 50000
`define PULSE_MIN_PERIOD             (`CLK_FREQ_HZ / `PULSE_MAX_HZ)
`define PULSE_PERIOD_FLOOR           16'h00c8

`endif

// file: design/hyst_compare.v
// Purpose: Hysteresis comparator with a percentage band below the ON level.
// Assumes: Unsigned quantities and a width percentage of at most 100.
// Notes:   The OFF level is computed each cycle from the current settings.
`timescale 1ns/100ps

// =====================================================================
// Hysteresis comparator
module hyst_compare #(
   parameter W = 16
) (
   input  wire         i_clk_sys,
   input  wire         i_reset_n,
   input  wire         i_enable,
   input  wire [W-1:0] i_value,
   input  wire [W-1:0] i_level,
   input  wire [6:0]   i_width_pct,
   output reg          o_on
);

   wire [W+6:0] band_prod;
   wire [W+6:0] band_full;
   wire [W-1:0] band;
   wire [W-1:0] off_level;

   // The band is level times percent over one hundred, rounded down.
   assign band_prod = i_level * i_width_pct;
   // The quotient never exceeds the level, so the upper bits are zero.
   assign band_full = band_prod / 7'h64;
   assign band      = band_full[W-1:0];
   assign off_level = i_level - band;

   // Above the level turns on, below the OFF level turns off, else hold.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_on <= 1'b0;
      end else if (!i_enable) begin
         o_on <= 1'b0;
      end else if (i_value > i_level) begin
         o_on <= 1'b1;
      end else if (i_value < off_level) begin
         o_on <= 1'b0;
      end
   end

endmodule // hyst_compare

// file: test/drive_io_chk.sv
// Purpose: Concurrent checks on the bus and first output of the terminal logic.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes:   Shadow flags follow bus writes so reset values and pulse mode can be judged.
`timescale 1ns/100ps
module drive_io_chk (
   input wire        i_clk_sys,
   input wire        i_reset_n,
   input wire [3:0]  i_addr,
   input wire [15:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [15:0] o_rdata,
   input wire        o_first_digital_output
);
   reg        pulse_q;
   reg        armed_q;
   reg        prev_q;
   reg [1:0]  wrote_q;
   reg [15:0] gap_q;
   // =====================================================================
   // Helper state: the first toggle after a mode write is not judged, since
   // the pulse phase there depends on when the write landed.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pulse_q <= 1'b0;
         armed_q <= 1'b0;
         prev_q  <= 1'b0;
         wrote_q <= 2'b00;
         gap_q   <= 16'h0000;
      end else begin
         prev_q <= o_first_digital_output;
         if (i_wr && i_addr == 4'h0) begin
            pulse_q <= i_wdata[0];
            armed_q <= 1'b0;
         end else if (pulse_q && o_first_digital_output != prev_q) begin
            armed_q <= 1'b1;
         end
         if (i_wr && i_addr == 4'ha) wrote_q[0] <= 1'b1;
         if (i_wr && i_addr == 4'hc) wrote_q[1] <= 1'b1;
         if (o_first_digital_output != prev_q) gap_q <= 16'h0000;
         else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
      end
   end
   // =====================================================================
   // Read-back ranges, reset values and pulse spacing.
   AST_TYPE_ONE_BIT: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata[15:1] == 15'h0000)
      else $error("type select reads back more than one bit");
   AST_PULSE_SPACING: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      pulse_q && armed_q && o_first_digital_output != prev_q |-> gap_q >= 16'h0062)
      else $error("pulse output toggles faster than the maximum rate");
   AST_FWIDTH_MAX: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $past(i_rd) && $past(i_addr) == 4'h6 |-> o_rdata <= 16'h0064)
      else $error("frequency width above full scale");
   AST_CURRENT_MAX: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $past(i_rd) && $past(i_addr) == 4'h7 |-> o_rdata <= 16'h1388)
      else $error("current level above full scale");
   AST_CWIDTH_MAX: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $past(i_rd) && $past(i_addr) == 4'h8 |-> o_rdata <= 16'h0064)
      else $error("current width above full scale");
   AST_THR_MAX: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $past(i_rd) && $past(i_addr) == 4'h9 |-> o_rdata <= 16'h01f4)
      else $error("arrival threshold above full scale");
   AST_IN_ONE_RESET: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $past(i_rd) && $past(i_addr) == 4'ha && !wrote_q[0] |-> o_rdata == 16'h000b)
      else $error("first input selector lost its reset value");
   AST_IN_THREE_RESET: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      $past(i_rd) && $past(i_addr) == 4'hc && !wrote_q[1] |-> o_rdata == 16'h000f)
      else $error("third input selector lost its reset value");
endmodule // drive_io_chk

bind drive_io_threshold_logic drive_io_chk u_chk (
   .i_clk_sys              (i_clk_sys),
   .i_reset_n              (i_reset_n),
   .i_addr                 (i_addr),
   .i_wdata                (i_wdata),
   .i_wr                   (i_wr),
   .i_rd                   (i_rd),
   .o_rdata                (o_rdata),
   .o_first_digital_output (o_first_digital_output)
);

// file: test/core_model.sv
// Purpose: Stand-in for the drive control core feeding the terminal logic.
// Assumes: The core publishes new quantities once per clock, its update cycle.
// Notes:   Quantities are zero while reset is held, as a halted core would show.
`timescale 1ns/100ps
module core_model (
   input  wire        i_clk_sys,
   input  wire        i_reset_n,
   input  wire [15:0] i_freq,
   input  wire [15:0] i_target,
   input  wire [15:0] i_current,
   output reg  [15:0] o_run_freq,
   output reg  [15:0] o_target_freq,
   output reg  [15:0] o_out_current
);
   // =====================================================================
   // One register stage models the core's update cycle.
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_run_freq    <= 16'h0000;
         o_target_freq <= 16'h0000;
         o_out_current <= 16'h0000;
      end else begin
         o_run_freq    <= i_freq;
         o_target_freq <= i_target;
         o_out_current <= i_current;
      end
   end
endmodule // core_model

// file: test/drive_io_threshold_logic_test.sv
// Purpose: Self-checking bench comparing the terminal logic with a behavioural model.
// Assumes: Core quantities settle in four clocks; pins settle in eight.
// Notes:   Random quantities come from an LFSR so every run is the same.
`timescale 1ns/100ps
`include "drive_io_defines.vh"
module drive_io_threshold_logic_test;
   reg         i_clk_sys;
   reg         i_reset_n;
   reg  [3:0]  i_addr;
   reg  [15:0] i_wdata;
   reg         i_wr;
   reg         i_rd;
   reg  [15:0] cmd_freq;
   reg  [15:0] cmd_target;
   reg  [15:0] cmd_current;
   reg  [2:0]  pins;
   reg  [15:0] lf;
   reg  [15:0] rd_val;
   reg         prev1;
   wire [15:0] o_rdata;
   wire [15:0] run_freq;
   wire [15:0] target_freq;
   wire [15:0] out_current;
   wire        out1;
   wire        out2;
   wire        relay;
   wire        run_cmd;
   wire        stop_cmd;
   integer     err_count;
   integer     samples_checked;
   integer     k;
   integer     p;
   integer     cnt;
   integer     f1_st;
   integer     f2_st;
   integer     cur_st;
   integer     arr_st;
   // =====================================================================
   // Design, partner core and clock.
   core_model u_core (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_freq(cmd_freq),
      .i_target(cmd_target), .i_current(cmd_current), .o_run_freq(run_freq),
      .o_target_freq(target_freq), .o_out_current(out_current));
   drive_io_threshold_logic u_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_run_freq(run_freq), .i_target_freq(target_freq), .i_out_current(out_current),
      .i_digital_input_one(pins[0]), .i_digital_input_two(pins[1]),
      .i_digital_input_three(pins[2]), .o_first_digital_output(out1),
      .o_second_digital_output(out2), .o_relay_output(relay), .o_run_cmd(run_cmd),
      .o_stop_cmd(stop_cmd));
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   // =====================================================================
   // Model functions, compares and bus tasks.
   function [15:0] nxt(input [15:0] x);
      nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function integer hyst(input integer st, input integer v, input integer lv, input integer pc);
      hyst = (v > lv) ? 1 : (v < lv - lv * pc / 100) ? 0 : st;
   endfunction
   function [15:0] rst_val(input integer a);
      case (a)
         4: rst_val = `RST_CHAR_FREQ_ONE;
         5: rst_val = `RST_CHAR_FREQ_TWO;
         6: rst_val = `RST_CHAR_FREQ_WIDTH;
         7: rst_val = 16'h0064;
         8: rst_val = `RST_CHAR_CURRENT_WIDTH;
         10: rst_val = `RST_INPUT_ONE_FUNCTION;
         11: rst_val = `RST_INPUT_TWO_FUNCTION;
         12: rst_val = `RST_INPUT_THREE_FUNCTION;
         13: rst_val = `RST_PULSE_PERIOD;
         default: rst_val = 16'h0000;
      endcase
   endfunction
   task end_sim;
      begin
         $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk_reg(input [15:0] e, input [15:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            $display("[FAIL] t=%0t reg exp %h got %h", $time, e, g);
            err_count = err_count + 1;
         end
      end
   endtask
   task chk_pin(input e, input g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            $display("[FAIL] t=%0t pin exp %h got %h", $time, e, g);
            err_count = err_count + 1;
         end
      end
   endtask
   task bus_wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge i_clk_sys);
         i_wr    <= 1'b1;
         i_addr  <= a;
         i_wdata <= d;
         @(posedge i_clk_sys);
         i_wr    <= 1'b0;
      end
   endtask
   task bus_rd(input [3:0] a);
      begin
         @(posedge i_clk_sys);
         i_rd   <= 1'b1;
         i_addr <= a;
         @(posedge i_clk_sys);
         i_rd   <= 1'b0;
         #1 rd_val = o_rdata;
      end
   endtask
   // One settled step of the core quantities against the hysteresis model.
   task step(input integer fn, input integer lv, input integer first);
      integer fv;
      integer cv;
      integer rv;
      begin
         lf = nxt(lf);
         fv = first ? lv + 1 : lv - 200 + lf % 300;
         cv = 80 + lf % 40;
         rv = fv - 100 + (lf >> 4) % 400;
         @(posedge i_clk_sys);
         cmd_freq    <= fv;
         cmd_current <= cv;
         cmd_target  <= rv[15:0];
         repeat (4) @(posedge i_clk_sys);
         #1;
         f1_st  = hyst(f1_st, fv, 1000, 10);
         f2_st  = hyst(f2_st, fv, 5000, 10);
         cur_st = hyst(cur_st, cv, 100, 10);
         arr_st = (fv >= rv) ? 0 : (fv >= rv - 200) ? 1 : arr_st;
         chk_pin((fn == 2) ? f1_st : (fn == 3) ? f2_st : 0, out1);
         chk_pin(cur_st, relay);
      end
   endtask
   // =====================================================================
   // Hang guard and main sequence.
   initial begin
      #3000000;
      err_count = err_count + 1;
      end_sim;
   end
   initial begin
      {i_wr, i_rd, i_addr, i_wdata, pins} = 0;
      {cmd_freq, cmd_target, cmd_current} = 0;
      {err_count, samples_checked, f1_st, f2_st, cur_st, arr_st} = 0;
      lf = 16'hefd3;
      i_reset_n = 1'b0;
      repeat (12) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      for (k = 0; k < 16; k = k + 1) begin
         bus_rd(k);
         chk_reg(rst_val(k), rd_val);
      end
      bus_wr(4'h6, 16'h00c8);
      bus_rd(4'h6);
      chk_reg(16'h0064, rd_val);
      bus_wr(4'h7, 16'h1770);
      bus_rd(4'h7);
      chk_reg(16'h1388, rd_val);
      bus_wr(4'h9, 16'h0258);
      bus_rd(4'h9);
      chk_reg(16'h01f4, rd_val);
      bus_wr(4'hd, 16'h0032);
      bus_rd(4'hd);
      chk_reg(16'h00c8, rd_val);
      bus_wr(4'h6, 16'h000a);
      bus_wr(4'h7, 16'h0064);
      bus_wr(4'h9, 16'h00c8);
      bus_wr(4'h1, `FN_CHAR_CURRENT);
      bus_wr(4'h3, `FN_FREQ_ARRIVAL);
      for (p = 0; p < 3; p = p + 1) begin
         bus_wr(4'h2, (p == 0) ? 16'h0002 : (p == 1) ? 16'h0003 : 16'h0001);
         for (k = 0; k < 40; k = k + 1) begin
            step((p == 0) ? 2 : (p == 1) ? 3 : 1, (p == 1) ? 5000 : 1000, k == 0);
            chk_pin(arr_st, out2);
         end
      end
      @(posedge i_clk_sys);
      pins <= 3'b111;
      repeat (8) @(posedge i_clk_sys);
      #1 chk_pin(1'b0, run_cmd | stop_cmd);
      bus_wr(4'ha, `IN_FN_RUN);
      bus_wr(4'hb, `IN_FN_STOP);
      bus_wr(4'hc, `IN_FN_RUN);
      for (p = 0; p < 9; p = p + 1) begin
         if (p == 8) bus_wr(4'hc, `IN_FN_NONE);
         @(posedge i_clk_sys);
         pins <= (p == 8) ? 3'b100 : p;
         repeat (8) @(posedge i_clk_sys);
         #1 chk_pin((p < 8) && (p[0] | p[2]), run_cmd);
         chk_pin(p[1], stop_cmd);
      end
      bus_wr(4'h2, 16'h0002);
      bus_wr(4'hd, 16'h00c8);
      bus_wr(4'h0, 16'h0001);
      bus_rd(4'h0);
      chk_reg(16'h0001, rd_val);
      repeat (300) @(posedge i_clk_sys);
      cnt = 0;
      #1 prev1 = out1;
      for (k = 0; k < 2000; k = k + 1) begin
         @(posedge i_clk_sys);
         #1 if (out1 !== prev1) cnt = cnt + 1;
         prev1 = out1;
      end
      chk_pin(1'b1, cnt >= 19 && cnt <= 21);
      bus_wr(4'h0, 16'h0000);
      end_sim;
   end
endmodule // drive_io_threshold_logic_test
